/* pkg/dcfc_pkg.sv */
// Constants, carrier types and state layout of the dual-clock FIFO controller.
// Assumes a single 50 MHz system clock and an APB master for configuration.
package dcfc_pkg;

	// Storage: sixteen blocks of 4608 bits, enough for every organisation.
	localparam int MAX_BLOCKS = 16;
	localparam int BLOCK_BITS = 4608;
	localparam int MEM_BITS = MAX_BLOCKS * BLOCK_BITS;
	localparam int PTR_W = 17;
	localparam int BIT_W = 17;
	localparam int DATA_W = 36;

	// Width selector codes.
	localparam logic [2:0] WIDTH_1 = 3'h0;
	localparam logic [2:0] WIDTH_2 = 3'h1;
	localparam logic [2:0] WIDTH_4 = 3'h2;
	localparam logic [2:0] WIDTH_9 = 3'h3;
	localparam logic [2:0] WIDTH_18 = 3'h4;
	localparam logic [2:0] WIDTH_36 = 3'h5;

	// Register byte offsets.
	localparam logic [11:0] ADDR_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

	// Control field positions.
	localparam int CTL_WIDTH_LSB = 0;
	localparam int CTL_DEPTH_LSB = 3;
	localparam logic [2:0] RESET_WIDTH = 3'h0;
	localparam logic [3:0] RESET_DEPTH = 4'h0;

	// Interrupt bit positions.
	localparam int IRQ_N = 4;
	localparam int IRQ_OVERFLOW = 0;
	localparam int IRQ_UNDERFLOW = 1;
	localparam int IRQ_FULL = 2;
	localparam int IRQ_EMPTY = 3;

	typedef struct packed {
		logic req;
		logic [DATA_W-1:0] data;
	} dcfc_push_type;

	typedef struct packed {
		logic valid;
		logic [DATA_W-1:0] data;
	} dcfc_pop_type;

	typedef struct packed {
		logic [2:0] width;
		logic [3:0] depth;
		logic [PTR_W-1:0] wp;
		logic [PTR_W-1:0] rp;
		logic [PTR_W-1:0] wp_rd1;
		logic [PTR_W-1:0] wp_rd2;
		logic [PTR_W-1:0] rp_wr1;
		logic [PTR_W-1:0] rp_wr2;
		logic full;
		logic empty;
		logic [IRQ_N-1:0] irq_status;
		logic [IRQ_N-1:0] irq_mask;
		logic pop_valid;
		logic [DATA_W-1:0] pop_data;
		logic [31:0] prdata;
		logic [MEM_BITS-1:0] mem;
	} dcfc_state_type;

	// Base depth of one block as a power of two, per width code.
	function automatic logic [4:0] base_log2(input logic [2:0] width);
		case (width)
			WIDTH_1: base_log2 = 5'd12;
			WIDTH_2: base_log2 = 5'd11;
			WIDTH_4: base_log2 = 5'd10;
			WIDTH_9: base_log2 = 5'd9;
			WIDTH_18: base_log2 = 5'd8;
			default: base_log2 = 5'd7;
		endcase
	endfunction : base_log2

	function automatic logic [5:0] bits_per_word(input logic [2:0] width);
		case (width)
			WIDTH_1: bits_per_word = 6'd1;
			WIDTH_2: bits_per_word = 6'd2;
			WIDTH_4: bits_per_word = 6'd4;
			WIDTH_9: bits_per_word = 6'd9;
			WIDTH_18: bits_per_word = 6'd18;
			default: bits_per_word = 6'd36;
		endcase
	endfunction : bits_per_word

	// Cascade depth as a power of two; the highest set select bit wins.
	function automatic logic [4:0] depth_log2(input logic [3:0] depth);
		if (depth[3])
			depth_log2 = 5'd4;
		else if (depth[2])
			depth_log2 = 5'd3;
		else if (depth[1])
			depth_log2 = 5'd2;
		else if (depth[0])
			depth_log2 = 5'd1;
		else
			depth_log2 = 5'd0;
	endfunction : depth_log2

endpackage : dcfc_pkg

/* sim/dcfc_controller_test.sv */
// Self-checking bench of the FIFO controller: fills and drains every width at one block and 36-bit words at each cascade depth; fills 1-bit at eight blocks.
// Assumes pready is answered by the design and the user model sits on the same clock.
`timescale 1ns/1ps
module dcfc_controller_test;
	logic clock, irq, full, empty, pready, pslverr, pop_req;
	logic rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic want_push = 1'b0, want_pop = 1'b0;
	logic [6:0] stall = 7'h00;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [2:0] cur_w = 3'h0;
	dcfc_pkg::dcfc_push_type push;
	dcfc_pkg::dcfc_pop_type pop;
	logic [35:0] q[$];
	int n_errors = 0, n_compared = 0;
	dcfc_controller dcfc_controller_i (.clock, .rst, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .push, .full, .pop_req, .pop, .empty, .irq);
	dcfc_user dcfc_user_i (.clock, .want_push, .want_pop, .stall, .push, .pop_req);
	////////////////////////////////////////
	function automatic int wbits(input logic [2:0] w);
		int t[6] = '{1, 2, 4, 9, 18, 36};
		return t[w];
	endfunction : wbits
	task automatic end_sim();
		if (n_errors == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	task automatic check(input string name, input logic [35:0] got, input logic [35:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic exp_err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n == 50)
		begin
			n_errors++;
			end_sim();
		end
		if (!wr)
			check("prdata", prdata, 36'(exp));
		check("pslverr", pslverr, exp_err);
		// A valid width write flushes the FIFO.
		if (wr && a == dcfc_pkg::ADDR_CONTROL && d[2:1] != 2'b11)
			q.delete();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic wait_flag(input bit on_empty, input int lim);
		int n;
		n = 0;
		while ((on_empty ? (empty !== 1'b1 || q.size() != 0) : full !== 1'b1) && n < lim)
		begin
			@(posedge clock);
			n++;
		end
		if (n == lim)
		begin
			n_errors++;
			end_sim();
		end
	endtask : wait_flag
	task automatic lag(input bit is_pop);
		if (is_pop)
			want_pop <= 1'b1;
		else
			want_push <= 1'b1;
		@(posedge clock);
		want_pop <= 1'b0;
		want_push <= 1'b0;
		for (int i = 1; i <= 3; i++)
		begin
			@(posedge clock);
			#1;
			check(is_pop ? "full" : "empty", is_pop ? full : empty, 36'(i < 3));
		end
	endtask : lag
	task automatic run(input logic [2:0] w, input logic [3:0] d, input int c, input bit drain);
		cur_w = w;
		stall <= 7'd0;
		apb(1'b1, dcfc_pkg::ADDR_CONTROL, {25'h0, d, w}, 0, 1'b0);
		apb(1'b0, dcfc_pkg::ADDR_CONTROL, 0, {25'h0, d, w}, 1'b0);
		apb(1'b1, dcfc_pkg::ADDR_IRQ_STATUS, 32'hF, 0, 1'b0);
		lag(1'b0);
		want_push <= 1'b1;
		wait_flag(1'b0, c + 20);
		repeat (3) @(posedge clock);
		want_push <= 1'b0;
		check("words", q.size(), c);
		apb(1'b0, dcfc_pkg::ADDR_STATUS, 0, 32'h2, 1'b0);
		if (!drain)
		begin
			apb(1'b1, dcfc_pkg::ADDR_CONTROL, 0, 0, 1'b0);
			cur_w = 3'h0;
			repeat (4) @(posedge clock);
			check("flushed", {full, empty}, 36'h1);
			return;
		end
		lag(1'b1);
		stall <= 7'd30;
		want_pop <= 1'b1;
		wait_flag(1'b1, 4 * c + 50);
		stall <= 7'd0;
		repeat (4) @(posedge clock);
		want_pop <= 1'b0;
		apb(1'b0, dcfc_pkg::ADDR_STATUS, 0, 32'h1, 1'b0);
		apb(1'b0, dcfc_pkg::ADDR_IRQ_STATUS, 0, 32'hF, 1'b0);
		check("irq masked", irq, 0);
		apb(1'b1, dcfc_pkg::ADDR_IRQ_MASK, 32'h2, 0, 1'b0);
		check("irq", irq, 1);
		apb(1'b1, dcfc_pkg::ADDR_IRQ_STATUS, 32'h2, 0, 1'b0);
		check("irq cleared", irq, 0);
		apb(1'b1, dcfc_pkg::ADDR_IRQ_MASK, 0, 0, 1'b0);
	endtask : run
	////////////////////////////////////////
	initial
	begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// Scoreboard: a word counts as taken only when full was low at that edge.
	always @(posedge clock)
	begin
		if (!rst && push.req && !full && !(psel && penable && pwrite && paddr == 12'h000))
			q.push_back(push.data & ((36'h1 << wbits(cur_w)) - 36'h1));
		if (!rst && pop.valid === 1'b1)
		begin
			if (q.size() == 0)
				check("spare pop", 1, 0);
			else
				check("pop data", pop.data, q.pop_front());
		end
	end
	initial
	begin
		void'($urandom(60736));
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		check("reset flags", {full, empty, irq, pop.valid}, 36'h4);
		apb(1'b1, 12'h010, 32'hFFFFFFFF, 0, 1'b1);
		apb(1'b0, 12'h010, 0, 0, 1'b1);
		apb(1'b1, dcfc_pkg::ADDR_IRQ_MASK, 0, 0, 1'b0);
		for (int r = 6; r < 8; r++)
		begin
			apb(1'b1, dcfc_pkg::ADDR_CONTROL, 32'(r), 0, 1'b0);
			apb(1'b0, dcfc_pkg::ADDR_CONTROL, 0, 0, 1'b0);
		end
		for (int w = 0; w < 6; w++)
			run(3'(w), 4'h0, 4096 >> w, 1'b1);
		for (int k = 0; k < 4; k++)
			run(3'h5, 4'(1 << k), 128 * (2 << k), 1'b1);
		run(3'h0, 4'h4, 32768, 1'b0);
		end_sim();
	end
endmodule : dcfc_controller_test

/* sim/dcfc_user.sv */
// Far-side user logic: pushes random words and pops, with optional random stalls.
// Assumes the controller samples both requests on the rising edge of clock.
`timescale 1ns/1ps
module dcfc_user
(
	// Clock and bench control
	input wire logic clock,
	input wire logic want_push,
	input wire logic want_pop,
	input wire logic [6:0] stall,
	// Controller side
	output dcfc_pkg::dcfc_push_type push,
	output logic pop_req
);
	initial
	begin
		push = '0;
		pop_req = 1'b0;
	end
	// clock synchronous requests
	// Data changes every cycle, so a stale word is never mistaken for a held one.
	always @(posedge clock)
	begin
		push.req <= want_push && ($urandom_range(99) >= stall);
		push.data <= 36'({$urandom, $urandom});
		pop_req <= want_pop && ($urandom_range(99) >= stall);
	end
endmodule : dcfc_user

/* src/dcfc_controller.sv */
// FIFO controller with wrap-bit pointers, two-stage pointer crossing and registered flags.
// Assumes one 50 MHz clock, an APB master for setup and push/pop logic on the same clock.
//
// Overview of operation
// - Pointers carry an extra wrap bit.
// - Empty when read and synced write pointers equal.
// - Write pointer passes two read-side stages.
// - Read pointer passes two write-side stages.
// - Write and read share one word width.
// - Three-bit selector picks six organisations; 11x reserved.
// - Four depth selects cascade 2, 4, 8, 16.
// - Eight one-bit blocks give 32768 entries.
// - Flags come straight from flip-flops, glitch-free.
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module dcfc_controller
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Push side
	input wire dcfc_pkg::dcfc_push_type push,
	output logic full,
	// Pop side
	input wire logic pop_req,
	output dcfc_pkg::dcfc_pop_type pop,
	output logic empty,
	// Interrupt
	output logic irq
);

	dcfc_pkg::dcfc_state_type s;
	dcfc_pkg::dcfc_state_type next_s;

	logic [4:0] cap_log2;
	logic [dcfc_pkg::PTR_W-1:0] cap;
	logic [dcfc_pkg::PTR_W-1:0] wrap_mask;
	logic [5:0] word_bits;
	logic setup;
	logic access;
	logic mapped;
	logic flush;
	logic push_ok;
	logic pop_ok;
	logic [dcfc_pkg::BIT_W-1:0] wr_base;
	logic [dcfc_pkg::BIT_W-1:0] rd_base;

	////////////////////////////////////////////////////////////////////////////////
	// Organisation decode

	always_comb
	begin
		cap_log2 = dcfc_pkg::base_log2(s.width) + dcfc_pkg::depth_log2(s.depth);
		cap = dcfc_pkg::PTR_W'(1) << cap_log2;
		wrap_mask = (cap << 1) - dcfc_pkg::PTR_W'(1);
		word_bits = dcfc_pkg::bits_per_word(s.width);
	end

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign mapped = (paddr == dcfc_pkg::ADDR_CONTROL) || (paddr == dcfc_pkg::ADDR_STATUS)
		|| (paddr == dcfc_pkg::ADDR_IRQ_STATUS) || (paddr == dcfc_pkg::ADDR_IRQ_MASK);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// reserved codes refused
	// A new organisation invalidates stored data, so the pointers restart.
	assign flush = access && pwrite && (paddr == dcfc_pkg::ADDR_CONTROL)
		&& (pwdata[dcfc_pkg::CTL_WIDTH_LSB+2 -: 2] != 2'h3);

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	assign push_ok = push.req && !s.full && !flush;
	assign pop_ok = pop_req && !s.empty && !flush;

	always_comb
	begin
		logic [22:0] wprod;
		logic [22:0] rprod;
		wprod = 23'((s.wp & (cap - dcfc_pkg::PTR_W'(1))) * word_bits);
		rprod = 23'((s.rp & (cap - dcfc_pkg::PTR_W'(1))) * word_bits);
		wr_base = wprod[dcfc_pkg::BIT_W-1:0];
		rd_base = rprod[dcfc_pkg::BIT_W-1:0];
		next_s = s;
		next_s.pop_valid = 1'b0;

		next_s.wp_rd1 = s.wp;
		next_s.wp_rd2 = s.wp_rd1;
		next_s.rp_wr1 = s.rp;
		next_s.rp_wr2 = s.rp_wr1;

		if (push_ok)
		begin
			for (int i = 0; i < dcfc_pkg::DATA_W; i++)
			begin
				if (6'(i) < word_bits)
					next_s.mem[wr_base + dcfc_pkg::BIT_W'(i)] = push.data[i];
			end
			next_s.wp = (s.wp + dcfc_pkg::PTR_W'(1)) & wrap_mask;
		end

		if (pop_ok)
		begin
			next_s.pop_valid = 1'b1;
			for (int i = 0; i < dcfc_pkg::DATA_W; i++)
			begin
				if (6'(i) < word_bits)
					next_s.pop_data[i] = s.mem[rd_base + dcfc_pkg::BIT_W'(i)];
				else
					next_s.pop_data[i] = 1'b0;
			end
			next_s.rp = (s.rp + dcfc_pkg::PTR_W'(1)) & wrap_mask;
		end

		if (flush)
		begin
			next_s.width = pwdata[dcfc_pkg::CTL_WIDTH_LSB +: 3];
			next_s.depth = pwdata[dcfc_pkg::CTL_DEPTH_LSB +: 4];
			next_s.wp = '0;
			next_s.rp = '0;
			next_s.wp_rd1 = '0;
			next_s.wp_rd2 = '0;
			next_s.rp_wr1 = '0;
			next_s.rp_wr2 = '0;
		end

		next_s.empty = (next_s.rp == next_s.wp_rd2);
		// full compare
		// The capacity after a flush is not known here; flags settle next cycle.
		next_s.full = ((next_s.wp ^ next_s.rp_wr2) == cap) && !flush;

		// Interrupt events; a set in the cycle of its clear survives.
		if (access && pwrite && (paddr == dcfc_pkg::ADDR_IRQ_STATUS))
			next_s.irq_status = s.irq_status & ~pwdata[dcfc_pkg::IRQ_N-1:0];
		if (access && pwrite && (paddr == dcfc_pkg::ADDR_IRQ_MASK))
			next_s.irq_mask = pwdata[dcfc_pkg::IRQ_N-1:0];
		if (push.req && s.full)
			next_s.irq_status[dcfc_pkg::IRQ_OVERFLOW] = 1'b1;
		if (pop_req && s.empty)
			next_s.irq_status[dcfc_pkg::IRQ_UNDERFLOW] = 1'b1;
		if (next_s.full && !s.full)
			next_s.irq_status[dcfc_pkg::IRQ_FULL] = 1'b1;
		if (next_s.empty && !s.empty)
			next_s.irq_status[dcfc_pkg::IRQ_EMPTY] = 1'b1;

		// Read data is captured in the setup cycle so the access needs no wait.
		if (setup)
		begin
			case (paddr)
				dcfc_pkg::ADDR_CONTROL:
					next_s.prdata = {25'h0000000, s.depth, s.width};
				dcfc_pkg::ADDR_STATUS:
					next_s.prdata = {30'h00000000, s.full, s.empty};
				dcfc_pkg::ADDR_IRQ_STATUS:
					next_s.prdata = {28'h0000000, s.irq_status};
				dcfc_pkg::ADDR_IRQ_MASK:
					next_s.prdata = {28'h0000000, s.irq_mask};
				default:
					next_s.prdata = 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			s <= '0;
			s.width <= dcfc_pkg::RESET_WIDTH;
			s.depth <= dcfc_pkg::RESET_DEPTH;
			s.empty <= 1'b1;
		end
		else
			s <= next_s;
	end

	assign prdata = s.prdata;
	assign full = s.full;
	assign empty = s.empty;
	assign pop.valid = s.pop_valid;
	assign pop.data = s.pop_data;
	assign irq = |(s.irq_status & s.irq_mask);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	logic flush_d1;
	logic flush_d2;
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			flush_d1 <= 1'b0;
			flush_d2 <= 1'b0;
		end
		else
		begin
			flush_d1 <= flush;
			flush_d2 <= flush_d1;
		end
	end

	property p_wrap_advance;
		@(posedge clock) disable iff (rst)
		push_ok |=> s.wp == (($past(s.wp) + 17'h00001) & $past(wrap_mask));
	endproperty
	a_wrap_advance: assert property (p_wrap_advance) else $error("write pointer bad step");

	property p_empty_eq;
		@(posedge clock) disable iff (rst)
		!flush_d1 |-> (s.empty == (s.rp == s.wp_rd2));
	endproperty
	a_empty_eq: assert property (p_empty_eq) else $error("empty flag mismatch");

	property p_wp_sync;
		@(posedge clock) disable iff (rst)
		(!flush_d1 && !flush_d2) ##1 !flush_d1 |-> s.wp_rd2 == $past(s.wp, 2);
	endproperty
	a_wp_sync: assert property (p_wp_sync) else $error("write pointer sync depth");

	property p_rp_sync;
		@(posedge clock) disable iff (rst)
		(!flush_d1 && !flush_d2) ##1 !flush_d1 |-> s.rp_wr2 == $past(s.rp, 2);
	endproperty
	a_rp_sync: assert property (p_rp_sync) else $error("read pointer sync depth");

	property p_width_legal;
		@(posedge clock) disable iff (rst)
		s.width[2:1] != 2'h3;
	endproperty
	a_width_legal: assert property (p_width_legal) else $error("reserved width held");

	property p_depth_eight;
		@(posedge clock) disable iff (rst)
		(s.width == dcfc_pkg::WIDTH_1 && s.depth == 4'h4) |-> cap == 17'h08000;
	endproperty
	a_depth_eight: assert property (p_depth_eight) else $error("eight block depth wrong");

	property p_flags_exclusive;
		@(posedge clock) disable iff (rst)
		!(s.full && s.empty);
	endproperty
	a_flags_exclusive: assert property (p_flags_exclusive) else $error("full and empty");

	property p_full_eq;
		@(posedge clock) disable iff (rst)
		!flush_d1 |-> (s.full == ((s.wp ^ s.rp_wr2) == cap));
	endproperty
	a_full_eq: assert property (p_full_eq) else $error("full flag mismatch");

	property p_no_push_full;
		@(posedge clock) disable iff (rst)
		(push.req && s.full && !flush) |=> $stable(s.wp) ##0 s.irq_status[0];
	endproperty
	a_no_push_full: assert property (p_no_push_full) else $error("push taken while full");

	property p_no_pop_empty;
		@(posedge clock) disable iff (rst)
		(pop_req && s.empty && !flush) |=> ($stable(s.rp) && !s.pop_valid);
	endproperty
	a_no_pop_empty: assert property (p_no_pop_empty) else $error("pop taken while empty");

	property p_wrap_bound;
		@(posedge clock) disable iff (rst)
		((s.wp & ~wrap_mask) == 17'h00000) && ((s.rp & ~wrap_mask) == 17'h00000);
	endproperty
	a_wrap_bound: assert property (p_wrap_bound) else $error("pointer beyond wrap bit");

	property p_pop_pulse;
		@(posedge clock) disable iff (rst)
		pop_ok |=> s.pop_valid;
	endproperty
	a_pop_pulse: assert property (p_pop_pulse) else $error("accepted pop not answered");

	property p_pop_idle;
		@(posedge clock) disable iff (rst)
		!pop_ok |=> !s.pop_valid;
	endproperty
	a_pop_idle: assert property (p_pop_idle) else $error("pop answered without request");

endmodule : dcfc_controller
